// >>> include/dbt_defines.svh
// register selects, field positions, reset values and counts of the trace block
`ifndef DBT_DEFINES_SVH
`define DBT_DEFINES_SVH
// ================================================================
// register selects
`define DBT_SEL_HIGH 2'h0
`define DBT_SEL_LOW 2'h1
`define DBT_SEL_CTRL 2'h2
// ================================================================
// trigger control fields
`define DBT_CTRL_TYPE_BIT 7
`define DBT_CTRL_BEGIN_BIT 6
`define DBT_CTRL_MODE_MSB 3
`define DBT_CTRL_MODE_LSB 0
`define DBT_CTRL_WMASK 8'hCF
`define DBT_CTRL_RESET 8'h00
// ================================================================
// capture fifo
`define DBT_FIFO_FULL 4'h8
`define DBT_FIFO_LAST 4'h7
`define DBT_HIGH_EVENT 8'h00
`define DBT_PRIME_READS 4'h8
`endif

// >>> include/dbt_pkg.sv
// types shared by the two ends of the trace block
package dbt_pkg;
   // ================================================================
   // trigger modes
   typedef enum logic [3:0] {
      MODE_A_ONLY = 4'h0,
      MODE_A_OR_B = 4'h1,
      MODE_A_THEN_B = 4'h2,
      MODE_EVT_B = 4'h3,
      MODE_A_THEN_EVT_B = 4'h4,
      MODE_A_AND_BD = 4'h5,
      MODE_A_NOT_BD = 4'h6,
      MODE_INSIDE = 4'h7,
      MODE_OUTSIDE = 4'h8
   } dbt_mode_type;
   // ================================================================
   // host commands
   typedef enum logic [2:0] {
      OP_READ_WORD = 3'h0,
      OP_READ_BYTE = 3'h1,
      OP_READ_CTRL = 3'h2,
      OP_WRITE_CTRL = 3'h3,
      OP_ARM = 3'h4,
      OP_DISARM = 3'h5,
      OP_PRIME = 3'h6
   } dbt_op_type;
   // ================================================================
   // host sequencer states
   typedef enum logic [3:0] {
      HS_IDLE = 4'h1,
      HS_WAIT_HI = 4'h2,
      HS_WAIT_LO = 4'h4,
      HS_PRIME = 4'h8
   } dbt_state_type;
endpackage : dbt_pkg

// >>> include/dbt_if.sv
// link between the processor side and the trace capture block
`timescale 1ns/1ps
interface dbt_if;
   logic [1:0] reg_sel;
   logic reg_rd;
   logic reg_wr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic arm_start;
   logic arm_clear;
   logic armed;
   logic [15:0] cmp_a;
   logic [15:0] cmp_b;
   logic [15:0] bus_addr;
   logic [7:0] bus_data;
   logic bus_access;
   logic fetch;
   logic exec;
   logic [15:0] exec_addr;

   modport dev (
      input reg_sel, reg_rd, reg_wr, reg_wdata, arm_start, arm_clear,
      input cmp_a, cmp_b, bus_addr, bus_data, bus_access, fetch, exec,
      input exec_addr,
      output reg_rdata, reg_rvalid, armed
   );
   modport core (
      output reg_sel, reg_rd, reg_wr, reg_wdata, arm_start, arm_clear,
      output cmp_a, cmp_b, bus_addr, bus_data, bus_access, fetch, exec,
      output exec_addr,
      input reg_rdata, reg_rvalid, armed
   );
endinterface : dbt_if

// >>> hdl/dbt_trace_dev.sv
// trace capture end: trigger decode, capture fifo and register windows
//
// Summary of operation
// - upper byte window read-only, writes ignored
// - event-only modes: upper byte reads zero
// - upper byte read leaves fifo position
// - lower byte read-only, read advances fifo
// - software reads upper before lower byte
// - event-only data: repeated lower reads suffice
// - armed: lower reads do not advance
// - software avoids fifo reads while armed
// - unarmed lower read stores last fetch address
// - profiling delays eight reads deep
// - software primes with eight discarded reads
// - control always readable, writable when unarmed
// - control bits 4 and 5 read zero
// - bit 7 selects access or executed opcode
// - bit 6 selects end or begin trace
// - event-only modes always begin trace
// - modes 0 to 3: A, A|B, A>B, evtB
// - modes 4 to 6: A>evtB, A&Bd, A&!Bd
// - 7 inside, 8 outside, rest never
`timescale 1ns/1ps
`include "dbt_defines.svh"
module dbt_trace_dev
   import dbt_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   dbt_if.dev link,
   output logic armed_o,
   output logic trig_o,
   output logic [3:0] fill_o
);

   // ================================================================
   // state
   logic [7:0] ctrl_q;
   logic armed_q;
   logic capt_q;
   logic a_seen_q;
   logic trig_q;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic [15:0] mem_q [0:7];
   logic [2:0] wptr_q;
   logic [2:0] rptr_q;
   logic [3:0] count_q;
   logic [15:0] last_fetch_q;

   logic [3:0] mode;
   logic evt_only;
   logic begin_trace;
   logic evt;
   logic [15:0] addr_v;
   logic hit_a;
   logic hit_b;
   logic data_eq;
   logic hit;
   logic store_en;
   logic [15:0] store_word;
   logic rd_low;
   logic wr_ctrl;
   logic stop;

   function automatic logic is_event_only(input logic [3:0] m);
      return (m == MODE_EVT_B) || (m == MODE_A_THEN_EVT_B);
   endfunction : is_event_only

   // ================================================================
   // comparators and trigger decode
   assign mode = ctrl_q[`DBT_CTRL_MODE_MSB:`DBT_CTRL_MODE_LSB];
   assign evt_only = is_event_only(mode);
   assign begin_trace = evt_only | ctrl_q[`DBT_CTRL_BEGIN_BIT];

   // tag mode looks at executed opcodes, force mode at every access
   always_comb begin
      if (ctrl_q[`DBT_CTRL_TYPE_BIT]) begin
         evt = link.exec;
         addr_v = link.exec_addr;
      end else begin
         evt = link.bus_access;
         addr_v = link.bus_addr;
      end
   end

   assign hit_a = evt && (addr_v == link.cmp_a);
   assign hit_b = evt && (addr_v == link.cmp_b);
   assign data_eq = link.bus_data == link.cmp_b[7:0];

   always_comb begin
      case (mode)
         MODE_A_ONLY: hit = hit_a;
         MODE_A_OR_B: hit = hit_a | hit_b;
         MODE_A_THEN_B: hit = a_seen_q & hit_b;
         MODE_EVT_B: hit = hit_b;
         MODE_A_THEN_EVT_B: hit = a_seen_q & hit_b;
         MODE_A_AND_BD: hit = hit_a & data_eq;
         MODE_A_NOT_BD: hit = hit_a & ~data_eq;
         MODE_INSIDE: begin
            hit = evt && (addr_v >= link.cmp_a)
                  && (addr_v <= link.cmp_b);
         end
         MODE_OUTSIDE: begin
            hit = evt && ((addr_v < link.cmp_a)
                  || (addr_v > link.cmp_b));
         end
         default: hit = 1'b0;
      endcase
   end

   // ================================================================
   // capture qualification
   always_comb begin
      if (evt_only) begin
         store_en = armed_q & hit;
         store_word = {`DBT_HIGH_EVENT, link.bus_data};
      end else begin
         store_en = armed_q & link.exec & (capt_q | (begin_trace & hit));
         store_word = link.exec_addr;
      end
   end

   // begin traces stop when full, end traces stop at the trigger
   assign stop = begin_trace ? (store_en && (count_q == `DBT_FIFO_LAST))
                             : (armed_q & hit);
   assign rd_low = link.reg_rd && (link.reg_sel == `DBT_SEL_LOW);
   assign wr_ctrl = link.reg_wr && (link.reg_sel == `DBT_SEL_CTRL);

   // ================================================================
   // control register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_q <= `DBT_CTRL_RESET;
      end else if (wr_ctrl && !armed_q) begin
         ctrl_q <= link.reg_wdata & `DBT_CTRL_WMASK;
      end
   end

   // ================================================================
   // arming and sequence state
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         armed_q <= 1'b0;
         capt_q <= 1'b0;
         a_seen_q <= 1'b0;
         trig_q <= 1'b0;
      end else begin
         trig_q <= armed_q & hit;
         // a fresh arm wins over any stop in the same cycle
         if (link.arm_start) begin
            armed_q <= 1'b1;
            capt_q <= ~begin_trace;
            a_seen_q <= 1'b0;
         end else begin
            if (link.arm_clear || stop) begin
               armed_q <= 1'b0;
            end
            if (armed_q && begin_trace && hit) begin
               capt_q <= 1'b1;
            end
            if (armed_q && hit_a) begin
               a_seen_q <= 1'b1;
            end
         end
      end
   end

   // ================================================================
   // pointers and fill level
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wptr_q <= 3'h0;
         rptr_q <= 3'h0;
         count_q <= 4'h0;
      end else if (link.arm_start) begin
         wptr_q <= 3'h0;
         rptr_q <= 3'h0;
         count_q <= 4'h0;
      end else begin
         if (store_en) begin
            wptr_q <= wptr_q + 3'h1;
            if (count_q != `DBT_FIFO_FULL) begin
               count_q <= count_q + 4'h1;
            end
         end
         // circular overwrite drops the oldest word
         if (store_en && (count_q == `DBT_FIFO_FULL)) begin
            rptr_q <= rptr_q + 3'h1;
         end else if (rd_low && !armed_q) begin
            rptr_q <= rptr_q + 3'h1;
         end
      end
   end

   // ================================================================
   // fifo storage and profiling
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         last_fetch_q <= 16'h0000;
      end else if (link.fetch) begin
         last_fetch_q <= link.bus_addr;
      end
   end

   // storing only happens armed, profiling only unarmed: no clash
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < 8; i++) begin
            mem_q[i] <= 16'h0000;
         end
      end else if (store_en) begin
         mem_q[wptr_q] <= store_word;
      end else if (rd_low && !armed_q) begin
         mem_q[rptr_q] <= last_fetch_q;
      end
   end

   // ================================================================
   // read windows; a high read touches no pointer
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= link.reg_rd;
         if (link.reg_rd) begin
            case (link.reg_sel)
               `DBT_SEL_HIGH: begin
                  rdata_q <= is_event_only(mode) ? `DBT_HIGH_EVENT
                                                 : mem_q[rptr_q][15:8];
               end
               `DBT_SEL_LOW: rdata_q <= mem_q[rptr_q][7:0];
               `DBT_SEL_CTRL: rdata_q <= ctrl_q;
               default: rdata_q <= 8'h00;
            endcase
         end
      end
   end

   assign link.reg_rdata = rdata_q;
   assign link.reg_rvalid = rvalid_q;
   assign link.armed = armed_q;
   assign armed_o = armed_q;
   assign trig_o = trig_q;
   assign fill_o = count_q;

endmodule : dbt_trace_dev

// >>> hdl/dbt_core_end.sv
// processor side of the trace block: register sequencer and bus feed
`timescale 1ns/1ps
`include "dbt_defines.svh"
module dbt_core_end
   import dbt_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   dbt_if.core link,
   input wire logic cmd_valid_i,
   input wire dbt_op_type cmd_op_i,
   input wire logic [7:0] cmd_data_i,
   output logic cmd_ready_o,
   output logic resp_valid_o,
   output logic resp_refused_o,
   output logic [15:0] resp_data_o,
   input wire logic [15:0] cmp_a_i,
   input wire logic [15:0] cmp_b_i,
   input wire logic [15:0] core_addr_i,
   input wire logic [7:0] core_data_i,
   input wire logic core_access_i,
   input wire logic core_fetch_i,
   input wire logic core_exec_i,
   input wire logic [15:0] core_exec_addr_i
);

   dbt_state_type state_q;
   logic ready_q;
   logic resp_valid_q;
   logic refused_q;
   logic [15:0] resp_q;
   logic [7:0] hi_q;
   logic [3:0] cnt_q;
   logic [1:0] sel_q;
   logic rd_q;
   logic wr_q;
   logic [7:0] wdata_q;
   logic arm_q;
   logic clr_q;
   logic [15:0] cmp_a_q;
   logic [15:0] cmp_b_q;
   logic [15:0] addr_q;
   logic [7:0] data_q;
   logic access_q;
   logic fetch_q;
   logic exec_q;
   logic [15:0] exec_addr_q;

   // ================================================================
   // bus activity feed, one cycle behind the core
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cmp_a_q <= 16'h0000;
         cmp_b_q <= 16'h0000;
         addr_q <= 16'h0000;
         data_q <= 8'h00;
         access_q <= 1'b0;
         fetch_q <= 1'b0;
         exec_q <= 1'b0;
         exec_addr_q <= 16'h0000;
      end else begin
         cmp_a_q <= cmp_a_i;
         cmp_b_q <= cmp_b_i;
         addr_q <= core_addr_i;
         data_q <= core_data_i;
         access_q <= core_access_i;
         fetch_q <= core_fetch_i;
         exec_q <= core_exec_i;
         exec_addr_q <= core_exec_addr_i;
      end
   end

   // ================================================================
   // register sequencer
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= HS_IDLE;
         ready_q <= 1'b1;
         resp_valid_q <= 1'b0;
         refused_q <= 1'b0;
         resp_q <= 16'h0000;
         hi_q <= 8'h00;
         cnt_q <= 4'h0;
         sel_q <= `DBT_SEL_HIGH;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         wdata_q <= 8'h00;
         arm_q <= 1'b0;
         clr_q <= 1'b0;
      end else begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         arm_q <= 1'b0;
         clr_q <= 1'b0;
         resp_valid_q <= 1'b0;
         refused_q <= 1'b0;
         case (state_q)
            HS_IDLE: begin
               if (cmd_valid_i && ready_q) begin
                  hi_q <= 8'h00;
                  // fifo reads while armed would disturb sequencing
                  if (link.armed && (cmd_op_i == OP_READ_WORD ||
                      cmd_op_i == OP_READ_BYTE || cmd_op_i == OP_PRIME)) begin
                     resp_valid_q <= 1'b1;
                     refused_q <= 1'b1;
                     resp_q <= 16'h0000;
                  end else begin
                     case (cmd_op_i)
                        OP_READ_WORD: begin
                           sel_q <= `DBT_SEL_HIGH;
                           rd_q <= 1'b1;
                           ready_q <= 1'b0;
                           state_q <= HS_WAIT_HI;
                        end
                        OP_READ_BYTE: begin
                           sel_q <= `DBT_SEL_LOW;
                           rd_q <= 1'b1;
                           ready_q <= 1'b0;
                           state_q <= HS_WAIT_LO;
                        end
                        OP_READ_CTRL: begin
                           sel_q <= `DBT_SEL_CTRL;
                           rd_q <= 1'b1;
                           ready_q <= 1'b0;
                           state_q <= HS_WAIT_LO;
                        end
                        OP_PRIME: begin
                           sel_q <= `DBT_SEL_LOW;
                           rd_q <= 1'b1;
                           cnt_q <= `DBT_PRIME_READS;
                           ready_q <= 1'b0;
                           state_q <= HS_PRIME;
                        end
                        OP_WRITE_CTRL: begin
                           sel_q <= `DBT_SEL_CTRL;
                           wr_q <= 1'b1;
                           wdata_q <= cmd_data_i;
                           resp_valid_q <= 1'b1;
                        end
                        OP_ARM: begin
                           arm_q <= 1'b1;
                           resp_valid_q <= 1'b1;
                        end
                        OP_DISARM: begin
                           clr_q <= 1'b1;
                           resp_valid_q <= 1'b1;
                        end
                        default: begin
                           resp_valid_q <= 1'b1;
                           refused_q <= 1'b1;
                        end
                     endcase
                  end
               end
            end
            HS_WAIT_HI: begin
               if (link.reg_rvalid) begin
                  hi_q <= link.reg_rdata;
                  sel_q <= `DBT_SEL_LOW;
                  rd_q <= 1'b1;
                  state_q <= HS_WAIT_LO;
               end
            end
            HS_WAIT_LO: begin
               if (link.reg_rvalid) begin
                  resp_q <= {hi_q, link.reg_rdata};
                  resp_valid_q <= 1'b1;
                  ready_q <= 1'b1;
                  state_q <= HS_IDLE;
               end
            end
            HS_PRIME: begin
               if (link.reg_rvalid) begin
                  if (cnt_q == 4'h1) begin
                     resp_q <= 16'h0000;
                     resp_valid_q <= 1'b1;
                     ready_q <= 1'b1;
                     state_q <= HS_IDLE;
                  end else begin
                     cnt_q <= cnt_q - 4'h1;
                     rd_q <= 1'b1;
                  end
               end
            end
            default: begin
               state_q <= HS_IDLE;
               ready_q <= 1'b1;
            end
         endcase
      end
   end

   assign link.reg_sel = sel_q;
   assign link.reg_rd = rd_q;
   assign link.reg_wr = wr_q;
   assign link.reg_wdata = wdata_q;
   assign link.arm_start = arm_q;
   assign link.arm_clear = clr_q;
   assign link.cmp_a = cmp_a_q;
   assign link.cmp_b = cmp_b_q;
   assign link.bus_addr = addr_q;
   assign link.bus_data = data_q;
   assign link.bus_access = access_q;
   assign link.fetch = fetch_q;
   assign link.exec = exec_q;
   assign link.exec_addr = exec_addr_q;
   assign cmd_ready_o = ready_q;
   assign resp_valid_o = resp_valid_q;
   assign resp_refused_o = refused_q;
   assign resp_data_o = resp_q;

endmodule : dbt_core_end

// >>> sim/dbt_properties.sv
// concurrent checks on the register and arm link of the trace block
`timescale 1ns/1ps
`include "dbt_defines.svh"
module dbt_properties (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [1:0] reg_sel,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic arm_start,
   input wire logic arm_clear,
   input wire logic armed
);
   logic [7:0] ctrl_q;
   logic evt_mode;
   // ================================================================
   // control shadow, updated only where the device may accept a write
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_q <= `DBT_CTRL_RESET;
      end else if (reg_wr && reg_sel == `DBT_SEL_CTRL && !armed) begin
         ctrl_q <= reg_wdata & `DBT_CTRL_WMASK;
      end
   end
   assign evt_mode = ctrl_q[3:0] == 4'h3 || ctrl_q[3:0] == 4'h4;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // ================================================================
   // register link
   property p_rd_answer; reg_rd |=> reg_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read without answer next cycle");
   property p_rvalid_cause; reg_rvalid |-> $past(reg_rd); endproperty
   a_rvalid_cause: assert property (p_rvalid_cause)
      else $error("answer without a read");
   // past value: a same-edge write must not count for this read
   property p_ctrl_read;
      reg_rd && reg_sel == `DBT_SEL_CTRL |=> reg_rdata == $past(ctrl_q);
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("control readback wrong");
   property p_evt_high;
      reg_rd && reg_sel == `DBT_SEL_HIGH && evt_mode |=> reg_rdata == 8'h00;
   endproperty
   a_evt_high: assert property (p_evt_high)
      else $error("upper byte not zero in event-only mode");
   property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
   a_hold: assert property (p_hold)
      else $error("read data moved without a read");
   // ================================================================
   // arming
   property p_arm; arm_start |=> armed; endproperty
   a_arm: assert property (p_arm)
      else $error("arm pulse did not arm");
   property p_rise; $rose(armed) |-> $past(arm_start); endproperty
   a_rise: assert property (p_rise)
      else $error("armed rose without arm pulse");
   property p_disarm; arm_clear && !arm_start |=> !armed; endproperty
   a_disarm: assert property (p_disarm)
      else $error("disarm pulse ignored");
endmodule : dbt_properties

// >>> sim/tb.sv
// self-checking bench joining both ends of the trace block
`timescale 1ns/1ps
`include "dbt_defines.svh"
module tb
   import dbt_pkg::*;
;
   logic clk_i, reset_n_i, cmd_valid_i, cmd_ready_o, resp_valid_o;
   logic resp_refused_o, armed_o, trig_o, core_access_i, core_fetch_i;
   logic core_exec_i, refused_seen;
   dbt_op_type cmd_op_i;
   logic [7:0] cmd_data_i, core_data_i;
   logic [15:0] resp_data_o, cmp_a_i, cmp_b_i, core_addr_i;
   logic [15:0] core_exec_addr_i, rd, exp_w;
   logic [3:0] fill_o;
   int bad_count, n_tests, trig_cnt, k;
   // {trigger expected, control written}; bits 5:4 set on even rows
   logic [8:0] rows [16] = '{9'h170, 9'h141, 9'h072, 9'h043, 9'h074,
      9'h145, 9'h076, 9'h147, 9'h078, 9'h049, 9'h07A, 9'h04B, 9'h07C,
      9'h04D, 9'h07E, 9'h04F};
   dbt_if link ();
   dbt_trace_dev u_dbt_trace_dev (.clk_i, .reset_n_i, .link(link),
      .armed_o, .trig_o, .fill_o);
   dbt_core_end u_dbt_core_end (.clk_i, .reset_n_i, .link(link),
      .cmd_valid_i, .cmd_op_i, .cmd_data_i, .cmd_ready_o, .resp_valid_o,
      .resp_refused_o, .resp_data_o, .cmp_a_i, .cmp_b_i, .core_addr_i,
      .core_data_i, .core_access_i, .core_fetch_i, .core_exec_i,
      .core_exec_addr_i);
   dbt_properties u_dbt_properties (.clk_i, .reset_n_i,
      .reg_sel(link.reg_sel), .reg_rd(link.reg_rd), .reg_wr(link.reg_wr),
      .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
      .reg_rvalid(link.reg_rvalid), .arm_start(link.arm_start),
      .arm_clear(link.arm_clear), .armed(link.armed));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // counted mid-cycle, well away from the edge that launches the pulse
   always @(negedge clk_i) begin
      if (trig_o === 1'b1) trig_cnt++;
   end
   // ================================================================
   // helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : step
   // one command, answer captured; inputs move 1 ns after the edge
   task automatic cmd(input dbt_op_type op, input logic [7:0] d);
      int i;
      cmd_op_i = op;
      cmd_data_i = d;
      cmd_valid_i = 1'b1;
      step(1);
      cmd_valid_i = 1'b0;
      for (i = 0; i < 40 && resp_valid_o !== 1'b1; i++) step(1);
      if (i == 40) begin
         bad_count++;
         test_done();
      end
      rd = resp_data_o;
      refused_seen = resp_refused_o;
      step(1);
   endtask : cmd
   task automatic bus(input logic a, input logic [15:0] ad,
         input logic [7:0] dt, input logic e, input logic [15:0] ea);
      core_access_i = a;
      core_addr_i = ad;
      core_data_i = dt;
      core_exec_i = e;
      core_exec_addr_i = ea;
      step(1);
   endtask : bus
   // ================================================================
   // main sequence
   initial begin
      reset_n_i = 1'b0;
      cmd_valid_i = 1'b0;
      cmd_op_i = OP_READ_CTRL;
      cmd_data_i = 8'h00;
      cmp_a_i = 16'h2000;
      cmp_b_i = 16'h2010;
      core_fetch_i = 1'b0;
      bad_count = 0;
      n_tests = 0;
      trig_cnt = 0;
      bus(1'b0, 16'h0000, 8'h00, 1'b0, 16'h0000);
      repeat (20) @(posedge clk_i);
      #1 reset_n_i = 1'b1;
      chk({15'h0, cmd_ready_o}, 16'h0001);
      chk({15'h0, armed_o}, 16'h0000);
      chk({12'h0, fill_o}, 16'h0000);
      cmd(OP_READ_CTRL, 8'h00);
      chk(rd, 16'h0000);
      // profiling: the first eight reads only prime the delay line
      for (k = 0; k < 10; k++) begin
         core_addr_i = 16'h3000 + 16'(k) * 16'h0101;
         core_fetch_i = 1'b1;
         step(1);
         core_fetch_i = 1'b0;
         step(2);
         cmd(OP_READ_WORD, 8'h00);
         exp_w = k < 8 ? 16'h0000 : 16'h3000 + 16'(k - 8) * 16'h0101;
         chk(rd, exp_w);
      end
      for (k = 0; k < 16; k++) begin
         cmd(OP_WRITE_CTRL, rows[k][7:0]);
         cmd(OP_READ_CTRL, 8'h00);
         chk(rd, {8'h00, rows[k][7:0] & `DBT_CTRL_WMASK});
         cmd(OP_ARM, 8'h00);
         step(2);
         trig_cnt = 0;
         bus(1'b1, 16'h2000, 8'h10, 1'b0, 16'h0000);
         bus(1'b0, 16'h0000, 8'h00, 1'b0, 16'h0000);
         step(4);
         chk(16'(trig_cnt), {15'h0, rows[k][8]});
         cmd(OP_DISARM, 8'h00);
      end
      // tag mode: the bare access and the foreign opcode must not start it
      cmd(OP_WRITE_CTRL, 8'hC0);
      cmd(OP_ARM, 8'h00);
      chk({12'h0, fill_o}, 16'h0000);
      trig_cnt = 0;
      bus(1'b1, 16'h2000, 8'h00, 1'b0, 16'h0000);
      bus(1'b0, 16'h0000, 8'h00, 1'b1, 16'h5000);
      for (k = 0; k < 8; k++) bus(1'b0, 16'h0, 8'h0, 1'b1, 16'h2000 + 16'(k));
      bus(1'b0, 16'h0000, 8'h00, 1'b0, 16'h0000);
      step(4);
      chk({15'h0, armed_o}, 16'h0000);
      chk({12'h0, fill_o}, 16'h0008);
      chk(16'(trig_cnt), 16'h0001);
      for (k = 0; k < 8; k++) begin
         cmd(OP_READ_WORD, 8'h00);
         chk(rd, 16'h2000 + 16'(k));
      end
      // end trace: circular fill from arm, the hit word is the last kept
      cmd(OP_WRITE_CTRL, 8'h80);
      cmd(OP_ARM, 8'h00);
      for (k = 0; k < 10; k++) begin
         bus(1'b0, 16'h0000, 8'h00, 1'b1, 16'h4000 + 16'(k));
      end
      bus(1'b0, 16'h0000, 8'h00, 1'b1, 16'h2000);
      bus(1'b0, 16'h0000, 8'h00, 1'b0, 16'h0000);
      step(4);
      chk({15'h0, armed_o}, 16'h0000);
      for (k = 0; k < 8; k++) begin
         cmd(OP_READ_WORD, 8'h00);
         exp_w = k < 7 ? 16'h4003 + 16'(k) : 16'h2000;
         chk(rd, exp_w);
      end
      // event-only with end trace selected still behaves as begin trace
      cmd(OP_WRITE_CTRL, 8'h03);
      cmd(OP_ARM, 8'h00);
      cmd(OP_WRITE_CTRL, 8'h00);
      cmd(OP_READ_CTRL, 8'h00);
      chk(rd, 16'h0003);
      cmd(OP_READ_BYTE, 8'h00);
      chk({15'h0, refused_seen}, 16'h0001);
      for (k = 0; k < 8; k++) bus(1'b1, 16'h2010, 8'hA0 + 8'(k), 1'b0, 16'h0);
      bus(1'b0, 16'h0000, 8'h00, 1'b0, 16'h0000);
      step(4);
      chk({15'h0, armed_o}, 16'h0000);
      cmd(OP_READ_WORD, 8'h00);
      chk(rd, 16'h00A0);
      for (k = 1; k < 8; k++) begin
         cmd(OP_READ_BYTE, 8'h00);
         chk(rd, {8'h00, 8'hA0 + 8'(k)});
      end
      // priming fills every slot with the last fetch address
      cmd(OP_WRITE_CTRL, 8'h00);
      core_addr_i = 16'h6100;
      core_fetch_i = 1'b1;
      step(1);
      core_fetch_i = 1'b0;
      step(2);
      cmd(OP_PRIME, 8'h00);
      chk(rd, 16'h0000);
      cmd(OP_READ_WORD, 8'h00);
      chk(rd, 16'h6100);
      test_done();
   end
endmodule : tb
